// *** core/fm_pkg.sv ***
// Purpose: Shared constants, register map and types of the frequency meter.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes: Also holds the small edge synchroniser used for both sampled clocks.
package fm_pkg;
   localparam logic [11:0] FM_CONTROL_A_OFS = 12'h000;
   localparam logic [11:0] FM_CONTROL_B_OFS = 12'h004;
   localparam logic [11:0] FM_CONFIG_A_OFS = 12'h008;
   localparam logic [11:0] FM_IENCLR_OFS = 12'h00C;
   localparam logic [11:0] FM_IENSET_OFS = 12'h010;
   localparam logic [11:0] FM_IFLAG_OFS = 12'h014;
   localparam logic [11:0] FM_STATUS_OFS = 12'h018;
   localparam logic [11:0] FM_VALUE_OFS = 12'h01C;
   localparam int FM_CA_SOFT_RST = 0;
   localparam int FM_CA_EN = 1;
   localparam int FM_CB_START = 0;
   localparam int FM_IF_DONE = 0;
   localparam int FM_ST_BUSY = 0;
   localparam int FM_ST_OVERFLOW = 1;
   localparam int FM_ST_SYNC = 2;
   localparam int FM_RN_W = 8;
   localparam int FM_CNT_W = 24;
   localparam logic [7:0] FM_RN_RST = 8'h00;
   localparam logic [23:0] FM_CNT_MAX = 24'hFFFFFF;
   localparam logic [1:0] FM_SYNC_CYC = 2'h2;
   typedef enum logic [1:0] {
      FM_IDLE = 2'b00,
      FM_ARM = 2'b01,
      FM_RUN = 2'b10
   } fm_state_t;
endpackage
`timescale 1ns/1ns
`default_nettype none
module fm_edge_sync
   import fm_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic din,
   output logic rise
);
   logic s1_q, s2_q, s3_q;
   logic s1_d, s2_d, s3_d;
   always_comb begin
      s1_d = din;
      s2_d = s1_q;
      s3_d = s2_q;
   end
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else if (ce) begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         s3_q <= s3_d;
      end
   end
   // Only the second and third stages feed the edge test.
   assign rise = s2_q & ~s3_q;
endmodule
`default_nettype wire

// *** core/fm_top.sv ***
// Purpose: Frequency meter counting a measured clock over reference periods.
// Assumes: Both clocks are far slower than sys_clk and sampled as plain inputs.
// Notes: APB answers in one access cycle; ce low freezes the whole block.
`timescale 1ns/1ns
`default_nettype none
module fm_top
   import fm_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ref_clk_in,
   input wire logic msr_clk_in,
   output logic irq
);
   function automatic logic fm_mapped(input logic [11:0] a);
      fm_mapped = (a[11:5] == 7'h00) && (a[1:0] == 2'h0);
   endfunction

   logic ref_rise, msr_rise;
   fm_edge_sync u_ref_sync (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .ce(ce),
      .din(ref_clk_in),
      .rise(ref_rise)
   );
   fm_edge_sync u_msr_sync (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .ce(ce),
      .din(msr_clk_in),
      .rise(msr_rise)
   );

   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d, pslverr_q, pslverr_d;
   logic enable_q, enable_d, pend_en_q, pend_en_d, pend_sw_q, pend_sw_d;
   logic [1:0] sync_cnt_q, sync_cnt_d;
   logic [7:0] ref_cycles_q, ref_cycles_d, ref_cnt_q, ref_cnt_d;
   logic [23:0] msr_cnt_q, msr_cnt_d, value_q, value_d;
   logic irq_en_q, irq_en_d, done_q, done_d, overflow_q, overflow_d, irq_q, irq_d;
   fm_state_t state_q, state_d;
   logic wr, start, done_set, done_clr, overflow_set, overflow_clr, finish, soft_clr;
   logic [7:0] ref_next;

   assign wr = ce && psel && penable && pready_q && pwrite && fm_mapped(paddr);

   always_comb begin
      prdata_d = prdata_q;
      pready_d = 1'b0;
      pslverr_d = 1'b0;
      enable_d = enable_q;
      pend_en_d = pend_en_q;
      pend_sw_d = pend_sw_q;
      sync_cnt_d = sync_cnt_q;
      ref_cycles_d = ref_cycles_q;
      ref_cnt_d = ref_cnt_q;
      msr_cnt_d = msr_cnt_q;
      value_d = value_q;
      irq_en_d = irq_en_q;
      state_d = state_q;
      start = 1'b0;
      done_set = 1'b0;
      done_clr = 1'b0;
      overflow_set = 1'b0;
      overflow_clr = 1'b0;
      finish = 1'b0;
      soft_clr = 1'b0;
      ref_next = ref_cnt_q + 8'h01;
      // The answer is prepared in the setup cycle so the access needs no wait.
      if (psel && !penable) begin
         pready_d = 1'b1;
         pslverr_d = !fm_mapped(paddr);
         prdata_d = 32'h00000000;
         if (!pwrite && fm_mapped(paddr)) begin
            unique case (paddr)
               FM_CONTROL_A_OFS: begin
                  prdata_d[FM_CA_EN] = enable_q;
               end
               FM_CONFIG_A_OFS: begin
                  prdata_d[FM_RN_W-1:0] = ref_cycles_q;
               end
               FM_IENCLR_OFS, FM_IENSET_OFS: begin
                  prdata_d[FM_IF_DONE] = irq_en_q;
               end
               FM_IFLAG_OFS: begin
                  prdata_d[FM_IF_DONE] = done_q;
               end
               FM_STATUS_OFS: begin
                  prdata_d[FM_ST_BUSY] = (state_q != FM_IDLE);
                  prdata_d[FM_ST_OVERFLOW] = overflow_q;
                  prdata_d[FM_ST_SYNC] = (sync_cnt_q != 2'h0);
               end
               FM_VALUE_OFS: begin
                  prdata_d[FM_CNT_W-1:0] = value_q;
               end
               default: begin
                  prdata_d = 32'h00000000;
               end
            endcase
         end
      end
      // FM_CONTROL_A_OFS writes land in a pending copy and take effect a fixed delay later.
      if (sync_cnt_q != 2'h0) begin
         sync_cnt_d = sync_cnt_q - 2'h1;
         if (sync_cnt_q == 2'h1) begin
            if (pend_sw_q) begin
               soft_clr = 1'b1;
            end else begin
               enable_d = pend_en_q;
            end
         end
      end
      if (wr) begin
         unique case (paddr)
            FM_CONTROL_A_OFS: begin
               // A write while the previous one is still in flight is dropped.
               if (sync_cnt_q == 2'h0) begin
                  pend_en_d = pwdata[FM_CA_EN];
                  pend_sw_d = pwdata[FM_CA_SOFT_RST];
                  sync_cnt_d = FM_SYNC_CYC;
               end
            end
            FM_CONTROL_B_OFS: begin
               start = pwdata[FM_CB_START] && enable_q && (state_q == FM_IDLE);
            end
            FM_CONFIG_A_OFS: begin
               ref_cycles_d = pwdata[FM_RN_W-1:0];
            end
            FM_IENCLR_OFS: begin
               if (pwdata[FM_IF_DONE]) begin
                  irq_en_d = 1'b0;
               end
            end
            FM_IENSET_OFS: begin
               if (pwdata[FM_IF_DONE]) begin
                  irq_en_d = 1'b1;
               end
            end
            FM_IFLAG_OFS: begin
               done_clr = pwdata[FM_IF_DONE];
            end
            FM_STATUS_OFS: begin
               overflow_clr = pwdata[FM_ST_OVERFLOW];
            end
            default: begin
               start = 1'b0;
            end
         endcase
      end
      unique case (state_q)
         FM_IDLE: begin
            if (start) begin
               state_d = FM_ARM;
               msr_cnt_d = 24'h000000;
               ref_cnt_d = 8'h00;
            end
         end
         FM_ARM: begin
            // The window opens on a reference edge so it spans whole periods.
            if (ref_rise) begin
               if (ref_cycles_q == 8'h00) begin
                  finish = 1'b1;
               end else begin
                  state_d = FM_RUN;
               end
            end
         end
         FM_RUN: begin
            if (msr_rise) begin
               if (msr_cnt_q == FM_CNT_MAX) begin
                  overflow_set = 1'b1;
               end else begin
                  msr_cnt_d = msr_cnt_q + 24'h000001;
               end
            end
            if (ref_rise) begin
               ref_cnt_d = ref_next;
               if (ref_next == ref_cycles_q) begin
                  finish = 1'b1;
               end
            end
         end
         default: begin
            state_d = FM_IDLE;
         end
      endcase
      if (finish) begin
         state_d = FM_IDLE;
         value_d = msr_cnt_d;
         done_set = 1'b1;
      end
      if (!enable_q) begin
         state_d = FM_IDLE;
         done_set = 1'b0;
      end
      // A hardware set in the same cycle as a clear wins.
      done_d = (done_q && !done_clr) || done_set;
      overflow_d = (overflow_q && !overflow_clr) || overflow_set;
      if (soft_clr) begin
         enable_d = 1'b0;
         pend_en_d = 1'b0;
         pend_sw_d = 1'b0;
         ref_cycles_d = FM_RN_RST;
         ref_cnt_d = 8'h00;
         msr_cnt_d = 24'h000000;
         value_d = 24'h000000;
         irq_en_d = 1'b0;
         done_d = 1'b0;
         overflow_d = 1'b0;
         state_d = FM_IDLE;
      end
      irq_d = done_d && irq_en_d;
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         prdata_q <= 32'h00000000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         enable_q <= 1'b0;
         pend_en_q <= 1'b0;
         pend_sw_q <= 1'b0;
         sync_cnt_q <= 2'h0;
         ref_cycles_q <= FM_RN_RST;
         ref_cnt_q <= 8'h00;
         msr_cnt_q <= 24'h000000;
         value_q <= 24'h000000;
         irq_en_q <= 1'b0;
         done_q <= 1'b0;
         overflow_q <= 1'b0;
         irq_q <= 1'b0;
         state_q <= FM_IDLE;
      end else if (ce) begin
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         enable_q <= enable_d;
         pend_en_q <= pend_en_d;
         pend_sw_q <= pend_sw_d;
         sync_cnt_q <= sync_cnt_d;
         ref_cycles_q <= ref_cycles_d;
         ref_cnt_q <= ref_cnt_d;
         msr_cnt_q <= msr_cnt_d;
         value_q <= value_d;
         irq_en_q <= irq_en_d;
         done_q <= done_d;
         overflow_q <= overflow_d;
         irq_q <= irq_d;
         state_q <= state_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign irq = irq_q;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   sequence en_write_s;
      ce && wr && paddr == FM_CONTROL_A_OFS && sync_cnt_q == 2'h0 && pwdata[FM_CA_EN]
         && !pwdata[FM_CA_SOFT_RST];
   endsequence
   sequence ce_held_s;
      ce ##1 ce;
   endsequence

   enable_sync_a: assert property (en_write_s ##1 ce_held_s |=> enable_q)
      else $error("enable not applied after sync delay");
   enable_late_a: assert property ((en_write_s and !enable_q) |=> !enable_q)
      else $error("enable applied before sync delay");
   soft_reset_a: assert property (ce && soft_clr |=> !enable_q
      && ref_cycles_q == FM_RN_RST && !irq_en_q)
      else $error("soft reset left state behind");
   busy_start_a: assert property (ce && start && !soft_clr |=> state_q != FM_IDLE)
      else $error("busy not raised on start");
   done_end_a: assert property (ce && finish && enable_q && !soft_clr |=> done_q
      && state_q == FM_IDLE && value_q == $past(msr_cnt_d))
      else $error("done flag or result missing at end");
   overflow_set_a: assert property (ce && state_q == FM_RUN && msr_rise
      && msr_cnt_q == FM_CNT_MAX && !soft_clr |=> overflow_q && msr_cnt_q == FM_CNT_MAX)
      else $error("overflow not flagged");
   overflow_clear_a: assert property (ce && overflow_clr && !overflow_set |=> !overflow_q)
      else $error("overflow not cleared by write");
   flag_clear_a: assert property (ce && done_clr && !done_set |=> !done_q)
      else $error("done flag not cleared by write");
   irq_level_a: assert property (irq_q |-> done_q && irq_en_q)
      else $error("interrupt without enabled flag");
   ien_set_a: assert property (ce && wr && paddr == FM_IENSET_OFS && pwdata[FM_IF_DONE]
      && !soft_clr |=> irq_en_q)
      else $error("interrupt enable set failed");
   idle_hold_a: assert property (ce && state_q == FM_IDLE && !start && !soft_clr
      |=> $stable(msr_cnt_q))
      else $error("count moved outside a measurement");
endmodule
`default_nettype wire

// *** dv/fm_top_test.sv ***
// Purpose: Self-checking bench for the frequency meter over its APB registers.
// Assumes: Reference period 40 sys_clk cycles, measured period 8, edges never coincide.
// Notes: Both sampled clocks run free; each reference period therefore holds exactly five measured edges.
`timescale 1ns/1ns
`default_nettype none
module clock_frequency_meter_test
   import fm_pkg::*;
   ;
   localparam int MSR_PER_REF = 5;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic ce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic ref_clk_in = 1'b0;
   logic msr_clk_in = 1'b0;
   logic irq;
   logic [31:0] rd;
   logic err;
   int error_cnt = 0;
   int checks = 0;
   int cyc = 0;

   fm_top DUT (.sys_clk(sys_clk), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ref_clk_in(ref_clk_in), .msr_clk_in(msr_clk_in), .irq(irq));

   initial begin
      forever #2 sys_clk = ~sys_clk;
   end

   // Measured edges fall two cycles after a reference edge could, so no count is ambiguous.
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      ref_clk_in <= (cyc % 40) < 20;
      msr_clk_in <= ((cyc + 6) % 8) < 4;
   end

   task automatic report_and_stop();
      if (error_cnt == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // The request stands until pready is seen high at a rising edge; data are taken there.
   task automatic apb(input logic we, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= we;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge sys_clk);
         if (pready === 1'b1) begin
            rd = prdata;
            err = pslverr;
            break;
         end
      end
      if (i == 20) begin
         error_cnt++;
         report_and_stop();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // The interrupt is registered, so it is looked at one edge after the access that moves it.
   task automatic chk_irq(input logic exp);
      @(posedge sys_clk);
      chk({31'h0, irq}, {31'h0, exp});
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   // Polls one STATUS bit until it reads zero, within a bounded number of reads.
   task automatic wait_low(input int bitpos);
      int i;
      for (i = 0; i < 500; i++) begin
         apb(1'b0, FM_STATUS_OFS, 32'h0);
         if (rd[bitpos] === 1'b0) begin
            break;
         end
      end
      if (i == 500) begin
         error_cnt++;
         report_and_stop();
      end
   endtask

   // Each start is placed well away from a reference edge, so that even a window of zero
   // periods is still busy when the first status read looks at it.
   task automatic measure(input logic [7:0] n);
      int i;
      wr(FM_CONTROL_A_OFS, 32'h0);
      wait_low(FM_ST_SYNC);
      wr(FM_CONFIG_A_OFS, {24'h0, n});
      wr(FM_CONTROL_A_OFS, 32'h2);
      wait_low(FM_ST_SYNC);
      wr(FM_IFLAG_OFS, 32'h1);
      for (i = 0; i < 40 && cyc % 40 != 10; i++) begin
         @(posedge sys_clk);
      end
      wr(FM_CONTROL_B_OFS, 32'h1);
      rdchk(FM_STATUS_OFS, 32'h1);
      wait_low(FM_ST_BUSY);
      rdchk(FM_IFLAG_OFS, 32'h1);
      rdchk(FM_VALUE_OFS, n * MSR_PER_REF);
      rdchk(FM_STATUS_OFS, 32'h0);
   endtask

   initial begin
      repeat (8) @(posedge sys_clk);
      rstn <= 1'b1;
      rdchk(FM_CONTROL_A_OFS, 32'h0);
      rdchk(FM_CONFIG_A_OFS, 32'h0);
      rdchk(FM_IENSET_OFS, 32'h0);
      rdchk(FM_IFLAG_OFS, 32'h0);
      rdchk(FM_VALUE_OFS, 32'h0);
      apb(1'b1, 12'h020, 32'hFFFFFFFF);
      chk({31'h0, err}, 32'h1);
      rdchk(12'h020, 32'h0);
      chk({31'h0, err}, 32'h1);
      wr(FM_CONFIG_A_OFS, 32'h3);
      wr(FM_CONTROL_B_OFS, 32'h1);
      rdchk(FM_STATUS_OFS, 32'h0);
      wr(FM_CONTROL_A_OFS, 32'h2);
      rdchk(FM_STATUS_OFS, 32'h4);
      wait_low(FM_ST_SYNC);
      rdchk(FM_CONTROL_A_OFS, 32'h2);
      wr(FM_IENSET_OFS, 32'h1);
      rdchk(FM_IENCLR_OFS, 32'h1);
      wr(FM_CONTROL_B_OFS, 32'h1);
      rdchk(FM_STATUS_OFS, 32'h1);
      chk_irq(1'b0);
      wait_low(FM_ST_BUSY);
      rdchk(FM_VALUE_OFS, 3 * MSR_PER_REF);
      chk_irq(1'b1);
      wr(FM_IFLAG_OFS, 32'h0);
      rdchk(FM_IFLAG_OFS, 32'h1);
      wr(FM_IENCLR_OFS, 32'h1);
      chk_irq(1'b0);
      wr(FM_IENSET_OFS, 32'h1);
      chk_irq(1'b1);
      wr(FM_IFLAG_OFS, 32'h1);
      rdchk(FM_IFLAG_OFS, 32'h0);
      chk_irq(1'b0);
      wr(FM_STATUS_OFS, 32'h2);
      rdchk(FM_STATUS_OFS, 32'h0);
      measure(8'h00);
      measure(8'h01);
      measure(8'h06);
      wr(FM_IFLAG_OFS, 32'h1);
      wr(FM_CONTROL_B_OFS, 32'h1);
      wr(FM_CONTROL_A_OFS, 32'h0);
      wait_low(FM_ST_SYNC);
      rdchk(FM_STATUS_OFS, 32'h0);
      rdchk(FM_IFLAG_OFS, 32'h0);
      wr(FM_CONTROL_A_OFS, 32'h2);
      wait_low(FM_ST_SYNC);
      wr(FM_CONTROL_A_OFS, 32'h1);
      wait_low(FM_ST_SYNC);
      rdchk(FM_CONTROL_A_OFS, 32'h0);
      rdchk(FM_CONFIG_A_OFS, 32'h0);
      rdchk(FM_IENSET_OFS, 32'h0);
      rdchk(FM_VALUE_OFS, 32'h0);
      report_and_stop();
   end
endmodule
`default_nettype wire
